// [verilog/dbg_host_pkg.sv]
/*
  Constants, types and the device register map for the debug link controller.
  Assumes a 40 MHz system clock and a target that follows the serial-wire or
  boundary-scan debug port packet formats.
*/
package dbg_host_pkg;
  // ----------------------------------------------------------------
  // Controller registers (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_WDATA  = 8'h04;
  localparam logic [7:0] OFS_RDATA  = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0C;
  localparam int CB_START    = 0;
  localparam int CB_RNW      = 1;
  localparam int CB_PORT     = 2;
  localparam int CB_FIELD    = 3;
  localparam int CB_SEL_SWD  = 8;
  localparam int CB_SEL_JTAG = 9;
  localparam int CB_PULSE    = 10;
  localparam int CB_CLR_ERR  = 11;
  localparam int CB_POWER    = 16;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ----------------------------------------------------------------
  // Target register map: port select bit 0 = debug port, 1 = access port
  // ----------------------------------------------------------------
  localparam logic [1:0] REG_DEBUG_PORT_IDENTIFICATION = 2'h0;
  localparam logic [1:0] REG_ACCESS_PORT_ABORT         = 2'h0;
  localparam logic [1:0] REG_DEBUG_PORT_CONTROL_STATUS = 2'h1;
  localparam logic [1:0] REG_ACCESS_PORT_SELECTOR      = 2'h2;
  localparam logic [1:0] REG_READ_RESULT_BUFFER        = 2'h3;
  localparam logic [1:0] REG_ACCESS_PORT_CONTROL_WORD  = 2'h0;
  localparam logic [1:0] REG_TRANSFER_ADDRESS          = 2'h1;
  localparam logic [1:0] REG_MEMORY_DATA_WINDOW        = 2'h3;
  // ----------------------------------------------------------------
  // Link sequences
  // ----------------------------------------------------------------
  localparam logic [2:0]  ACK_OK         = 3'h1;
  localparam logic [2:0]  ACK_FAIL       = 3'h7;
  localparam logic [15:0] SEL_SWD_PAT    = 16'h79E7;
  localparam logic [15:0] SEL_JTAG_PAT   = 16'h3CE7;
  localparam logic [15:0] PRE_LAST       = 16'h0031;
  localparam logic [15:0] SEL_LAST       = 16'h000F;
  localparam logic [15:0] POST_SWD_LAST  = 16'h0031;
  localparam logic [15:0] POST_JTAG_LAST = 16'h0004;
  localparam logic [15:0] REQ_LAST       = 16'h0007;
  localparam logic [15:0] ACK_LAST       = 16'h0002;
  localparam logic [15:0] DATA_LAST      = 16'h0020;
  localparam logic [15:0] TAIL_LAST      = 16'h0007;
  localparam logic [15:0] JTAG_LAST      = 16'h0030;
  localparam logic [15:0] JDR_FIRST      = 16'h000C;
  localparam logic [15:0] JDR_LAST       = 16'h002E;
  localparam logic [3:0]  IR_DP_ACCESS   = 4'hA;
  localparam logic [3:0]  IR_AP_ACCESS   = 4'hB;
  localparam logic [48:0] JTAG_TMS       = 49'h0C00000000383;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ         = 40;
  localparam int RESET_PULSE_NS  = 1000;
  localparam int RESET_PULSE_CYC = (RESET_PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam int LINK_HALF_DIV   = 4;
  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    S_IDLE = 4'h0, S_PRE  = 4'h1, S_SEL  = 4'h2, S_POST = 4'h3,
    S_REQ  = 4'h4, S_TRN1 = 4'h5, S_ACK  = 4'h6, S_TRN2 = 4'h7,
    S_DATA = 4'h8, S_TRN3 = 4'h9, S_TAIL = 4'hA, S_JTAG = 4'hB,
    S_RST  = 4'hC
  } state_e;
  typedef struct packed {
    logic       port;
    logic [1:0] field;
    logic       rnw;
  } txn_s;
  typedef struct packed {
    logic [23:0] zero;
    logic        power;
    logic        swd;
    logic        err;
    logic [2:0]  ack;
    logic        done;
    logic        busy;
  } status_s;
endpackage : dbg_host_pkg

// [verilog/debug_link_host.sv]
/*
  Debug link host: drives a target's shared clock, data/mode, test data and
  reset pins, and runs select sequences and single register transactions.
  Assumes an AXI4-Lite master on the same clock and a target on the pins.
*/
`timescale 1ns/1ps
// Operation
// - Select sequence opens each session; the host also runs transactions without one, in boundary-scan mode after reset
// - Write sends 32 bits, gets 3-bit acknowledge
// - Port bit 0 debug, 1 access port
// - Parity mismatch becomes failing code 111
// - Code 001 is success, then parity checked
// - Failed transaction reported; software retries or stops
// - Debug port register codes by direction
// - Access port register codes
// - Dedicated reset output pulsed
// - Target power switched by state bit
// - Only single reads and writes on link
// - Failure stops flow until cleared
// - Serial-wire select: 50 high, 79E7, 50
// - Boundary-scan select: 50 high, 3CE7, 5
// - Reset line active low
module debug_link_host
  import dbg_host_pkg::*;
#(
  parameter int HALF_DIV = LINK_HALF_DIV,
  parameter int RST_CYC  = RESET_PULSE_CYC
) (
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        awvalid,
  output      logic        awready,
  input  wire logic [7:0]  awaddr,
  input  wire logic        wvalid,
  output      logic        wready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  output      logic        bvalid,
  input  wire logic        bready,
  output      logic [1:0]  bresp,
  input  wire logic        arvalid,
  output      logic        arready,
  input  wire logic [7:0]  araddr,
  output      logic        rvalid,
  input  wire logic        rready,
  output      logic [31:0] rdata,
  output      logic [1:0]  rresp,
  output      logic        shared_link_clock_pin,
  input  wire logic        shared_data_mode_pin_i,
  output      logic        shared_data_mode_pin_o,
  output      logic        shared_data_mode_pin_oe,
  output      logic        test_data_in_pin,
  input  wire logic        test_data_out_pin,
  output      logic        external_reset_pin_b,
  output      logic        target_power
);
  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  state_e      state_r;
  logic [15:0] cnt_r;
  logic [7:0]  div_r;
  logic        clk_r;
  logic        sel_swd_r;
  logic        proto_swd_r;
  logic        done_r;
  logic        err_r;
  logic        power_r;
  logic        ext_rst_b_r;
  txn_s        txn_r;
  logic [31:0] wdata_r;
  logic [31:0] rdata_r;
  logic [2:0]  ack_r;
  logic [34:0] sh_r;
  logic [2:0]  dio_s;
  logic [2:0]  tdo_s;
  logic        dio_f;
  logic        tdo_f;
  logic        dio_o_r;
  logic        dio_oe_r;
  logic        tdi_r;
  logic        bvalid_r;
  logic [1:0]  bresp_r;
  logic        rvalid_r;
  logic [31:0] rdat_r;
  logic [1:0]  rresp_r;
  logic        wr_go;
  logic        ar_go;
  logic        wr_ctrl;
  logic        cmd_start;
  logic        cmd_sel_swd;
  logic        cmd_sel_jtag;
  logic        cmd_pulse;
  logic        cmd_clr_err;
  logic        idle;
  logic        start_ok;
  logic        link_run;
  logic        tick;
  logic        rise;
  logic        fall;
  logic        finish_txn;
  logic        in_bit;
  logic [2:0]  res_ack;
  logic [7:0]  req_v;
  logic [32:0] wd_v;
  logic [48:0] tdi_v;
  logic        drv_o;
  logic        drv_oe;
  logic        drv_tdi;
  status_s     st;

  // ----------------------------------------------------------------
  // Pin input synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      dio_s <= 3'h0;
      tdo_s <= 3'h0;
    end else begin
      dio_s <= {dio_s[1:0], shared_data_mode_pin_i};
      tdo_s <= {tdo_s[1:0], test_data_out_pin};
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      dio_f <= 1'b0;
      tdo_f <= 1'b0;
    end else begin
      if (dio_s[1] == dio_s[2]) dio_f <= dio_s[2];
      if (tdo_s[1] == tdo_s[2]) tdo_f <= tdo_s[2];
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------
  assign wr_go        = awvalid && wvalid && !bvalid_r;
  assign awready      = wr_go;
  assign wready       = wr_go;
  assign ar_go        = arvalid && !rvalid_r;
  assign arready      = !rvalid_r;
  assign bvalid       = bvalid_r;
  assign bresp        = bresp_r;
  assign rvalid       = rvalid_r;
  assign rdata        = rdat_r;
  assign rresp        = rresp_r;
  assign wr_ctrl      = wr_go && (awaddr == OFS_CTRL);
  assign idle         = (state_r == S_IDLE);
  assign cmd_start    = wr_ctrl && wstrb[0] && wdata[CB_START];
  assign cmd_sel_swd  = wr_ctrl && wstrb[1] && wdata[CB_SEL_SWD];
  assign cmd_sel_jtag = wr_ctrl && wstrb[1] && wdata[CB_SEL_JTAG] && !cmd_sel_swd;
  assign cmd_pulse    = wr_ctrl && wstrb[1] && wdata[CB_PULSE];
  assign cmd_clr_err  = wr_ctrl && wstrb[1] && wdata[CB_CLR_ERR];
  assign start_ok     = cmd_start && idle && !err_r && !cmd_pulse && !cmd_sel_swd && !cmd_sel_jtag;
  assign st           = '{zero: 24'h0, power: power_r, swd: proto_swd_r, err: err_r,
                          ack: ack_r, done: done_r, busy: !idle};

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      bvalid_r <= 1'b0;
      bresp_r  <= RESP_OKAY;
    end else if (wr_go) begin
      bvalid_r <= 1'b1;
      bresp_r  <= (awaddr[7:4] == 4'h0 && awaddr[1:0] == 2'h0) ? RESP_OKAY : RESP_SLVERR;
    end else if (bready) begin
      bvalid_r <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wdata_r <= 32'h0;
      power_r <= 1'b0;
    end else if (wr_go) begin
      if (awaddr == OFS_WDATA && idle) begin
        for (int i = 0; i < 4; i++) begin
          if (wstrb[i]) wdata_r[i*8 +: 8] <= wdata[i*8 +: 8];
        end
      end
      if (wr_ctrl && wstrb[2]) power_r <= wdata[CB_POWER];
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rvalid_r <= 1'b0;
      rdat_r   <= 32'h0;
      rresp_r  <= RESP_OKAY;
    end else if (ar_go) begin
      rvalid_r <= 1'b1;
      rresp_r  <= RESP_OKAY;
      case (araddr)
        OFS_CTRL:   rdat_r <= {15'h0, power_r, 16'h0};
        OFS_WDATA:  rdat_r <= wdata_r;
        OFS_RDATA:  rdat_r <= rdata_r;
        OFS_STATUS: rdat_r <= st;
        default: begin
          rdat_r  <= 32'h0;
          rresp_r <= RESP_SLVERR;
        end
      endcase
    end else if (rready) begin
      rvalid_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Link clock divider
  // ----------------------------------------------------------------
  assign link_run = !idle && (state_r != S_RST);
  assign tick     = (div_r == 8'(HALF_DIV - 1));
  assign rise     = link_run && tick && !clk_r;
  assign fall     = link_run && tick && clk_r;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      div_r <= 8'h00;
      clk_r <= 1'b0;
    end else if (!link_run) begin
      div_r <= 8'h00;
      clk_r <= 1'b0;
    end else if (tick) begin
      div_r <= 8'h00;
      clk_r <= !clk_r;
    end else begin
      div_r <= div_r + 8'h01;
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_r     <= S_IDLE;
      cnt_r       <= 16'h0000;
      sel_swd_r   <= 1'b0;
      proto_swd_r <= 1'b0;
      done_r      <= 1'b0;
    end else if (idle) begin
      cnt_r <= 16'h0000;
      if (cmd_pulse) begin
        state_r <= S_RST;
        done_r  <= 1'b0;
      end else if (cmd_sel_swd || cmd_sel_jtag) begin
        state_r   <= S_PRE;
        sel_swd_r <= cmd_sel_swd;
        done_r    <= 1'b0;
      end else if (start_ok) begin
        state_r <= proto_swd_r ? S_REQ : S_JTAG;
        done_r  <= 1'b0;
      end
    end else if (state_r == S_RST) begin
      cnt_r <= cnt_r + 16'h0001;
      if (cnt_r == 16'(RST_CYC - 1)) begin
        state_r <= S_IDLE;
        done_r  <= 1'b1;
      end
    end else if (fall) begin
      cnt_r <= cnt_r + 16'h0001;
      case (state_r)
        S_PRE: if (cnt_r == PRE_LAST) begin
          state_r <= S_SEL;
          cnt_r   <= 16'h0000;
        end
        S_SEL: if (cnt_r == SEL_LAST) begin
          state_r <= S_POST;
          cnt_r   <= 16'h0000;
        end
        S_POST: if (cnt_r == (sel_swd_r ? POST_SWD_LAST : POST_JTAG_LAST)) begin
          state_r     <= S_IDLE;
          proto_swd_r <= sel_swd_r;
          done_r      <= 1'b1;
        end
        S_REQ: if (cnt_r == REQ_LAST) begin
          state_r <= S_TRN1;
          cnt_r   <= 16'h0000;
        end
        S_TRN1: begin
          state_r <= S_ACK;
          cnt_r   <= 16'h0000;
        end
        S_ACK: if (cnt_r == ACK_LAST) begin
          cnt_r <= 16'h0000;
          if (ack_r != ACK_OK) state_r <= S_TRN3;
          else if (txn_r.rnw) state_r <= S_DATA;
          else state_r <= S_TRN2;
        end
        S_TRN2: begin
          state_r <= S_DATA;
          cnt_r   <= 16'h0000;
        end
        S_DATA: if (cnt_r == DATA_LAST) begin
          state_r <= txn_r.rnw ? S_TRN3 : S_TAIL;
          cnt_r   <= 16'h0000;
        end
        S_TRN3: begin
          state_r <= S_TAIL;
          cnt_r   <= 16'h0000;
        end
        S_TAIL: if (cnt_r == TAIL_LAST) begin
          state_r <= S_IDLE;
          done_r  <= 1'b1;
        end
        S_JTAG: if (cnt_r == JTAG_LAST) begin
          state_r <= S_IDLE;
          done_r  <= 1'b1;
        end
        default: state_r <= S_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      txn_r <= '0;
    end else if (start_ok) begin
      txn_r <= '{port: wdata[CB_PORT], field: wdata[CB_FIELD +: 2], rnw: wdata[CB_RNW]};
    end
  end

  // ----------------------------------------------------------------
  // Capture and outcome
  // ----------------------------------------------------------------
  assign finish_txn = fall && ((state_r == S_TAIL && cnt_r == TAIL_LAST) ||
                               (state_r == S_JTAG && cnt_r == JTAG_LAST));
  assign in_bit     = (state_r == S_JTAG) ? tdo_f : dio_f;

  always_comb begin
    res_ack = ack_r;
    if (!proto_swd_r) begin
      res_ack = sh_r[2:0];
    end else if (txn_r.rnw && ack_r == ACK_OK && ((^sh_r[33:2]) != sh_r[34])) begin
      res_ack = ACK_FAIL;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ack_r   <= 3'h0;
      sh_r    <= 35'h0;
      rdata_r <= 32'h0;
      err_r   <= 1'b0;
    end else begin
      if (rise && state_r == S_ACK) ack_r[cnt_r[1:0]] <= dio_f;
      // Test data out moves on the falling link edge; the sync chain needs a full bit to show it
      if ((rise && state_r == S_DATA && txn_r.rnw) ||
          (fall && state_r == S_JTAG && cnt_r >= JDR_FIRST && cnt_r <= JDR_LAST)) begin
        sh_r <= {in_bit, sh_r[34:1]};
      end
      if (cmd_clr_err) err_r <= 1'b0;
      if (finish_txn) begin
        ack_r <= res_ack;
        err_r <= (res_ack != ACK_OK);
        if (txn_r.rnw && res_ack == ACK_OK) rdata_r <= proto_swd_r ? sh_r[33:2] : sh_r[34:3];
      end
    end
  end

  // ----------------------------------------------------------------
  // Pin drive
  // ----------------------------------------------------------------
  assign req_v = {1'b1, 1'b0, txn_r.port ^ txn_r.rnw ^ (^txn_r.field),
                  txn_r.field[1], txn_r.field[0], txn_r.rnw, txn_r.port, 1'b1};
  assign wd_v  = {^wdata_r, wdata_r};
  assign tdi_v = {2'b00, wdata_r, txn_r.field, txn_r.rnw, 4'h0,
                  txn_r.port ? IR_AP_ACCESS : IR_DP_ACCESS, 4'h0};

  always_comb begin
    drv_o   = 1'b1;
    drv_oe  = 1'b1;
    drv_tdi = 1'b0;
    case (state_r)
      S_SEL:  drv_o = sel_swd_r ? SEL_SWD_PAT[4'hF - cnt_r[3:0]] : SEL_JTAG_PAT[4'hF - cnt_r[3:0]];
      S_REQ:  drv_o = req_v[cnt_r[2:0]];
      S_TRN1, S_ACK, S_TRN2, S_TRN3: drv_oe = 1'b0;
      S_DATA: begin
        drv_oe = !txn_r.rnw;
        drv_o  = wd_v[cnt_r[5:0]];
      end
      S_TAIL: drv_o = 1'b0;
      S_JTAG: begin
        drv_o   = JTAG_TMS[cnt_r[5:0]];
        drv_tdi = tdi_v[cnt_r[5:0]];
      end
      default: drv_o = 1'b1;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      dio_o_r     <= 1'b1;
      dio_oe_r    <= 1'b1;
      tdi_r       <= 1'b0;
      ext_rst_b_r <= 1'b1;
    end else begin
      ext_rst_b_r <= (state_r != S_RST);
      if (!clk_r) begin
        dio_o_r  <= drv_o;
        dio_oe_r <= drv_oe;
        tdi_r    <= drv_tdi;
      end
    end
  end

  assign shared_link_clock_pin   = clk_r;
  assign shared_data_mode_pin_o  = dio_o_r;
  assign shared_data_mode_pin_oe = dio_oe_r;
  assign test_data_in_pin        = tdi_r;
  assign external_reset_pin_b    = ext_rst_b_r;
  assign target_power            = power_r;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  a_pre_high: assert property ((state_r == S_PRE && clk_r) |-> dio_o_r && dio_oe_r)
    else $error("select preamble not high");
  a_req_port: assert property ((state_r == S_REQ && clk_r && cnt_r == 16'h0001) |-> dio_o_r == txn_r.port)
    else $error("port select bit wrong");
  a_req_parity: assert property ((state_r == S_REQ && clk_r && cnt_r == 16'h0005)
      |-> dio_o_r == (txn_r.port ^ txn_r.rnw ^ (^txn_r.field)))
    else $error("request parity wrong");
  a_parity_fail: assert property ((finish_txn && proto_swd_r && txn_r.rnw && ack_r == ACK_OK
      && ((^sh_r[33:2]) != sh_r[34])) |=> ack_r == ACK_FAIL && err_r)
    else $error("parity mismatch not failed");
  a_ack_fail: assert property ((finish_txn && res_ack != ACK_OK) |=> err_r && done_r && idle)
    else $error("failed acknowledge not flagged");
  a_jtag_noparity: assert property ((finish_txn && !proto_swd_r && sh_r[2:0] == ACK_OK) |=> !err_r)
    else $error("boundary-scan read failed on ok");
  a_reset_pulse: assert property ($fell(external_reset_pin_b) |-> !external_reset_pin_b[*8]
      ##[1:1000] external_reset_pin_b)
    else $error("reset pulse malformed");
  a_one_txn: assert property ((cmd_start && !idle) |=> $stable(txn_r))
    else $error("transaction overlapped");
  a_err_blocks: assert property ((cmd_start && err_r && idle && !cmd_pulse && !cmd_sel_swd
      && !cmd_sel_jtag) |=> idle)
    else $error("start taken while failed");
  a_power_set: assert property ((wr_ctrl && wstrb[2]) |=> target_power == $past(wdata[CB_POWER]))
    else $error("power state not applied");
endmodule : debug_link_host

// [tb/dbg_target_model.sv]
/*
  Behavioural debug port target: serial-wire and boundary-scan register access.
  Assumes the bench resolves the shared data line and supplies power and reset.
*/
`timescale 1ns/1ps
module dbg_target_model
  import dbg_host_pkg::*;
#(
  parameter logic [31:0] IDC = 32'h0000_0000
) (
  input  wire logic       lclk,
  input  wire logic       dio,
  input  wire logic       tdi,
  input  wire logic       rst_pin_b,
  input  wire logic       pwr,
  input  wire logic [2:0] ack_code,
  input  wire logic       bad_par,
  output      logic       do_o,
  output      logic       do_oe,
  output      logic       tdo
);
  logic [31:0] mem [8];
  logic [31:0] d, prev;
  logic [34:0] jo, ji;
  logic [15:0] sh, n;
  logic [5:0]  cnt;
  logic [6:0]  idx, k;
  logic [3:0]  ir;
  logic [2:0]  ra, jr;
  logic        swd, act, rnw, jv;
  realtime     tl;
  wire         live = pwr & rst_pin_b;
  wire  [31:0] rv   = (ra == 3'h0) ? IDC : mem[ra];
  // ------------------------------
  // Link side
  // ------------------------------
  initial begin
    do_oe = 1'b0;
    tdo = 1'b0;
  end
  always @(posedge lclk or negedge live) begin
    if (!live) begin
      swd <= 1'b0;
      act <= 1'b0;
      do_oe <= 1'b0;
      idx <= 7'h0;
      prev <= 32'h0;
      for (int i = 0; i < 8; i++) mem[i] <= 32'h0;
    end else begin
      n = {sh[14:0], dio};
      k = ($realtime - tl > 300.0) ? 7'h0 : idx;
      sh <= n;
      tl <= $realtime;
      idx <= k + 7'h1;
      if (k > 7'h40 && n == SEL_SWD_PAT) swd <= 1'b1;
      if (k > 7'h40 && n == SEL_JTAG_PAT) swd <= 1'b0;
      if (swd && k == 7'h7 && n[7] && !n[1] && n[0] && !(^n[6:2])) begin
        act <= 1'b1;
        cnt <= 6'h1;
        rnw <= n[5];
        ra <= {n[6], n[3], n[4]};
      end
      if (act) begin
        cnt <= cnt + 6'h1;
        if (cnt < 6'h4) begin
          do_oe <= 1'b1;
          do_o <= ack_code[cnt - 6'h1];
        end else if (cnt == 6'h4 && (ack_code != ACK_OK || !rnw)) begin
          do_oe <= 1'b0;
          act <= (ack_code == ACK_OK);
        end else if (rnw && cnt < 6'h24) do_o <= rv[cnt - 6'h4];
        else if (rnw && cnt == 6'h24) do_o <= ^rv ^ bad_par;
        else if (cnt == 6'h25) do_oe <= 1'b0;
        if (!rnw && cnt > 6'h5 && cnt < 6'h26) d[cnt - 6'h6] <= dio;
        if (cnt == 6'h26) begin
          act <= 1'b0;
          if (!rnw && (^d == dio) && ra != 3'h0) mem[ra] <= d;
        end
      end
      if (k == 7'h3) jv <= (n[3:0] == 4'hC);
      if (k > 7'h3 && k < 7'h8) ir[k - 7'h4] <= tdi;
      if (k == 7'hB) jo <= {prev, ack_code};
      if (k > 7'hB && k < 7'h2F) ji[k - 7'hC] <= tdi;
      if (k == 7'h2F && jv && !swd) begin
        jr = {ir == IR_AP_ACCESS, ji[2:1]};
        if (ji[0]) prev <= (jr == 3'h0) ? IDC : mem[jr];
        else if (jr != 3'h0) mem[jr] <= ji[34:3];
      end
    end
  end
  always @(negedge lclk) tdo <= (idx > 7'hB && idx < 7'h2F) ? jo[idx - 7'hC] : ~tdo;
endmodule : dbg_target_model

// [tb/tb_debug_link_host.sv]
/*
  Bench for the debug link host: AXI4-Lite register tests against a target model.
  Assumes the design package and host module; clock 40 MHz.
*/
`timescale 1ns/1ps
module tb_debug_link_host
  import dbg_host_pkg::*;
;
  localparam logic [31:0] TID = 32'h0A5A_5A51;  // Arbitrary identification value
  logic        clk, rst_b, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready;
  logic        rvalid, rready, lclk, d_o, d_oe, tdi, tdo, rst_pin_b, pwr, t_o, t_oe, bad_par, last;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rdv, st;
  logic [1:0]  bresp, rresp, br, rr;
  logic [2:0]  ack_code;
  logic [2:0]  pf [4] = '{3'h5, 3'h4, 3'h7, 3'h1};
  int          n_fail, checks, tn, lowc;
  wire         dwire = d_oe ? d_o : (t_oe ? t_o : ~last);
  debug_link_host debug_link_host_inst (
    .clk, .rst_b, .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata, .wstrb(4'hF),
    .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid, .rready, .rdata, .rresp,
    .shared_link_clock_pin(lclk), .shared_data_mode_pin_i(dwire), .shared_data_mode_pin_o(d_o),
    .shared_data_mode_pin_oe(d_oe), .test_data_in_pin(tdi), .test_data_out_pin(tdo),
    .external_reset_pin_b(rst_pin_b), .target_power(pwr));
  dbg_target_model #(.IDC(TID)) dbg_target_model_inst (
    .lclk, .dio(dwire), .tdi, .rst_pin_b, .pwr, .ack_code, .bad_par, .do_o(t_o), .do_oe(t_oe), .tdo);
  // ------------------------------
  // Clock, line keeper, tasks
  // ------------------------------
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) if (d_oe || t_oe) last <= dwire;
  always @(posedge clk) if (!rst_pin_b) lowc++;
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    awaddr <= a;
    wdata <= d;
    do @(posedge clk); while (awready !== 1'b1);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    do @(posedge clk); while (bvalid !== 1'b1);
    br = bresp;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    arvalid <= 1'b1;
    araddr <= a;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clk); while (rvalid !== 1'b1);
    rdv = rdata;
    rr = rresp;
  endtask : rd
  task automatic cmd(input logic [31:0] c);
    wr(OFS_CTRL, c | 32'h0001_0000);
    rd(OFS_STATUS);
    for (int i = 0; i < 3000 && rdv[0] !== 1'b0; i++) rd(OFS_STATUS);
    st = rdv;
  endtask : cmd
  task automatic op(input logic p, input logic [1:0] f, input logic rnw, input logic [31:0] d);
    wr(OFS_WDATA, d);
    cmd({27'h0, f, p, rnw, 1'b1});
  endtask : op
  task automatic done_t();
    tn++;
    $display("test %0d ended", tn);
  endtask : done_t
  task automatic end_sim();
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : end_sim
  initial begin
    #(60000 * 25);
    n_fail++;
    end_sim();
  end
  // ------------------------------
  // Tests
  // ------------------------------
  initial begin
    {awvalid, wvalid, arvalid, bad_par, rst_b, last, awaddr, araddr, wdata} = '0;
    {bready, rready} = 2'h3;
    ack_code = ACK_OK;
    {n_fail, checks, tn, lowc} = '0;
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    chk({rst_pin_b, pwr, lclk, d_o, d_oe}, 5'h13);
    rd(OFS_STATUS);
    chk(rdv, 32'h0);
    rd(8'h10);
    chk(rr, RESP_SLVERR);
    wr(8'h14, 32'h0);
    chk(br, RESP_SLVERR);
    done_t();
    wr(OFS_CTRL, 32'h0001_0000);
    chk(pwr, 1'b1);
    lowc = 0;
    cmd(32'h0000_0400);
    repeat (50) @(posedge clk);
    chk(lowc, RESET_PULSE_CYC);
    done_t();
    op(1'b1, 2'h1, 1'b0, 32'h0800_0000);
    chk(st[6:2], {1'b0, 1'b0, ACK_OK});
    op(1'b1, 2'h1, 1'b1, 32'h0);
    op(1'b0, 2'h3, 1'b1, 32'h0);
    rd(OFS_RDATA);
    chk(rdv, 32'h0800_0000);
    done_t();
    cmd(32'h0000_0100);
    chk({st[6], dbg_target_model_inst.swd}, 2'h3);
    op(1'b0, 2'h0, 1'b1, 32'h0);
    rd(OFS_RDATA);
    chk(rdv, TID);
    op(1'b0, 2'h0, 1'b0, 32'h0000_001E);
    chk(st[5:2], {1'b0, ACK_OK});
    for (int i = 0; i < 4; i++) begin
      op(pf[i][2], pf[i][1:0], 1'b0, 32'hC0DE_0000 + i);
      chk(st[5:2], {1'b0, ACK_OK});
      op(pf[i][2], pf[i][1:0], 1'b1, 32'h0);
      rd(OFS_RDATA);
      chk(rdv, 32'hC0DE_0000 + i);
    end
    done_t();
    bad_par <= 1'b1;
    op(1'b1, 2'h1, 1'b1, 32'h0);
    chk(st[5:2], {1'b1, ACK_FAIL});
    rd(OFS_RDATA);
    chk(rdv, 32'hC0DE_0003);
    bad_par <= 1'b0;
    op(1'b1, 2'h1, 1'b0, 32'h0000_0BAD);
    chk(dbg_target_model_inst.mem[5], 32'hC0DE_0000);
    cmd(32'h0000_0800);
    chk(st[5], 1'b0);
    op(1'b1, 2'h1, 1'b1, 32'h0);
    rd(OFS_RDATA);
    chk(rdv, 32'hC0DE_0000);
    ack_code <= 3'h2;
    op(1'b1, 2'h1, 1'b0, 32'h0000_0001);
    chk(st[5:2], 4'hA);
    chk(dbg_target_model_inst.mem[5], 32'hC0DE_0000);
    ack_code <= ACK_OK;
    cmd(32'h0000_0800);
    wr(OFS_WDATA, 32'h0000_0001);
    wr(OFS_CTRL, 32'h0001_000D);
    wr(OFS_CTRL, 32'h0001_001F);
    cmd(32'h0);
    chk(st[5:2], {1'b0, ACK_OK});
    chk(dbg_target_model_inst.mem[5], 32'h0000_0001);
    done_t();
    cmd(32'h0000_0200);
    chk({st[6], dbg_target_model_inst.swd}, 2'h0);
    wr(OFS_CTRL, 32'h0);
    chk(pwr, 1'b0);
    done_t();
    end_sim();
  end
endmodule : tb_debug_link_host
